//--- hdl/sler_pkg.sv
// Package: constants and carriers for the link error recovery block
package sler_pkg;
  localparam int unsigned IS_IFS_BIT       = 27;
  localparam int unsigned SERR_LSEQ_BIT    = 23;
  localparam int unsigned PWR_CMD_LSB      = 14;
  localparam int unsigned PWR_CMD_MSB      = 21;
  localparam int unsigned PWR_CMD_W        = 8;
  localparam logic [7:0]  PWR_CMD_OFF      = 8'h00;
  localparam logic [7:0]  PWR_CMD_ON       = 8'h02;
  localparam int unsigned REG_FIS_MAX_DW   = 8;
  localparam int unsigned FIFO_DEPTH       = 8;
  localparam int unsigned DW_W             = 32;
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned PWR_OFF_NS       = 1000;
  localparam int unsigned PWR_OFF_CYC      = (PWR_OFF_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CMD_TMO_US       = 40;
  localparam int unsigned CMD_TMO_CYC      = CMD_TMO_US * CLK_MHZ;
  localparam int unsigned OOB_NS           = 2000;
  localparam int unsigned OOB_CYC          = (OOB_NS * CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic            sof;
    logic            eof;
    logic            reg_fis;
    logic [31:0]     data;
  } sler_rx_dw_t;

  typedef struct packed {
    logic            ifs;
    logic            lseq;
    logic            fifo_ovf;
    logic            cmd_tmo;
    logic            rx_lost;
  } sler_err_t;

  typedef enum logic [4:0] {
    ST_OOB    = 5'b00001,
    ST_LINK   = 5'b00010,
    ST_LOCK   = 5'b00100,
    ST_PWROFF = 5'b01000,
    ST_PWRON  = 5'b10000
  } sler_state_t;
endpackage

//--- hdl/sler_fifo.sv
// Receive FIFO with valid/ready on both sides
`timescale 1ns/10ps
module sler_fifo #(
  parameter int unsigned WIDTH = 35,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;
  logic [AW-1:0]    rp_nxt;

  // Output word kept in a register so the drain side sees stable data
  assign push   = in_valid && in_ready;
  assign pop    = out_valid && out_ready;
  assign rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || flush) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_nxt;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (srst || flush) begin
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      in_ready <= (cnt_r + (AW+1)'(push) - (AW+1)'(pop)) < (AW+1)'(DEPTH);
      if (!out_valid || out_ready) begin
        out_valid <= (cnt_r - (AW+1)'(pop)) != '0 && !(out_valid && cnt_r == (AW+1)'(1));
        out_data  <= out_valid ? mem_r[rp_nxt] : mem_r[rp_r];
      end
    end
  end
endmodule

//--- hdl/sler_core.sv
// Link error detection and recovery for a serial storage host port
`timescale 1ns/10ps
module sler_core #(
  parameter int unsigned TMO_CYC = sler_pkg::CMD_TMO_CYC
) (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic                port_reset,
  input  wire logic                link_illegal,
  input  wire logic                cont_corrupt,
  input  wire logic                cmd_active,
  input  wire logic                cmd_done,
  input  wire logic                low_power,
  input  wire logic                pll_relock,
  input  wire logic                phy_lock_pin,
  input  wire logic                drive_present_pin,
  input  wire sler_pkg::sler_rx_dw_t rx_dw,
  input  wire logic                rx_valid,
  output logic                     rx_ready,
  output sler_pkg::sler_rx_dw_t    out_dw,
  output logic                     out_valid,
  input  wire logic                out_ready,
  output logic [31:0]              port_irq_status,
  output logic [31:0]              port_error,
  output sler_pkg::sler_err_t      err_flags,
  output logic [31:0]              serial_phy_power_control,
  output logic                     link_up,
  output logic                     oob_start
);
  localparam int unsigned FW = $bits(sler_pkg::sler_rx_dw_t);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] lock_s_r;
  logic [1:0] drv_s_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      lock_s_r <= 2'b00;
      drv_s_r  <= 2'b00;
    end else begin
      lock_s_r <= {lock_s_r[0], phy_lock_pin};
      drv_s_r  <= {drv_s_r[0], drive_present_pin};
    end
  end

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  sler_pkg::sler_state_t st_r;
  sler_pkg::sler_state_t st_nxt;
  logic [15:0] tcnt_r;
  logic [3:0]  fis_cnt_r;
  logic        lp_relock_r;
  logic        ovf;
  logic        locked;
  logic        fifo_in_ready;
  logic        fifo_in_valid;

  assign locked = (st_r == sler_pkg::ST_LOCK);

  // Oversized register frame: ninth word of one frame
  assign ovf = rx_valid && rx_dw.reg_fis && !rx_dw.sof &&
               (fis_cnt_r == 4'(sler_pkg::REG_FIS_MAX_DW));

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      sler_pkg::ST_OOB: begin
        if (tcnt_r == 16'(sler_pkg::OOB_CYC - 1) && drv_s_r[1]) begin
          st_nxt = sler_pkg::ST_LINK;
        end
      end
      sler_pkg::ST_LINK: begin
        if (link_illegal || cont_corrupt || ovf) begin
          st_nxt = sler_pkg::ST_LOCK;
        end else if (lp_relock_r && low_power) begin
          st_nxt = sler_pkg::ST_PWROFF;
        end
      end
      sler_pkg::ST_LOCK: begin
        st_nxt = sler_pkg::ST_LOCK; // Only a port reset leaves here; srst also returns to ST_OOB
      end
      sler_pkg::ST_PWROFF: begin
        if (tcnt_r == 16'(sler_pkg::PWR_OFF_CYC - 1)) begin
          st_nxt = sler_pkg::ST_PWRON;
        end
      end
      sler_pkg::ST_PWRON: begin
        if (lock_s_r[1]) begin
          st_nxt = sler_pkg::ST_OOB;
        end
      end
      default: st_nxt = sler_pkg::ST_OOB;
    endcase
    if (port_reset) begin
      st_nxt = sler_pkg::ST_OOB;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= sler_pkg::ST_OOB;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || st_nxt != st_r || port_reset) begin
      tcnt_r <= '0;
    end else if (tcnt_r != 16'hffff) begin
      tcnt_r <= tcnt_r + 16'h0001;
    end
  end

  // Relock seen during low power is remembered until power-off or port reset
  always_ff @(posedge clk) begin
    if (srst) begin
      lp_relock_r <= 1'b0;
    end else if (pll_relock && low_power) begin
      lp_relock_r <= 1'b1;
    end else if (port_reset || st_r == sler_pkg::ST_PWROFF) begin
      lp_relock_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || port_reset) begin
      fis_cnt_r <= '0;
    end else if (rx_valid && rx_ready && rx_dw.reg_fis) begin
      if (rx_dw.sof) begin
        fis_cnt_r <= 4'h1;
      end else if (fis_cnt_r != 4'hf) begin
        fis_cnt_r <= fis_cnt_r + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command timeout
  // ----------------------------------------------------------------
  logic [31:0] cmd_t_r;
  logic        tmo;
  assign tmo = (cmd_t_r == 32'(TMO_CYC - 1));
  always_ff @(posedge clk) begin
    if (srst || port_reset || !cmd_active || cmd_done) begin
      cmd_t_r <= '0;
    end else if (!tmo) begin
      cmd_t_r <= cmd_t_r + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Status and error flags, set wins over reset clear
  // ----------------------------------------------------------------
  logic set_seq;
  assign set_seq = (st_r == sler_pkg::ST_LINK) && link_illegal;

  always_ff @(posedge clk) begin
    if (srst) begin
      port_irq_status <= '0;
      port_error      <= '0;
      err_flags       <= '0;
    end else begin
      if (set_seq) begin
        port_irq_status[sler_pkg::IS_IFS_BIT] <= 1'b1;
        port_error[sler_pkg::SERR_LSEQ_BIT]   <= 1'b1;
        err_flags.ifs  <= 1'b1;
        err_flags.lseq <= 1'b1;
      end else if (port_reset) begin
        port_irq_status <= '0;
        port_error      <= '0;
        err_flags.ifs   <= 1'b0;
        err_flags.lseq  <= 1'b0;
      end
      err_flags.fifo_ovf <= (ovf && st_r == sler_pkg::ST_LINK) ||
                            (err_flags.fifo_ovf && !port_reset);
      err_flags.cmd_tmo  <= (tmo && cmd_active) || (err_flags.cmd_tmo && !port_reset);
      err_flags.rx_lost  <= (lp_relock_r && low_power) ||
                            (err_flags.rx_lost && st_r != sler_pkg::ST_PWRON);
    end
  end

  // ----------------------------------------------------------------
  // PHY power command and link outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      serial_phy_power_control <= '0;
      link_up                  <= 1'b0;
      oob_start                <= 1'b0;
    end else begin
      if (st_nxt == sler_pkg::ST_PWROFF) begin
        serial_phy_power_control[sler_pkg::PWR_CMD_MSB:sler_pkg::PWR_CMD_LSB]
          <= sler_pkg::PWR_CMD_OFF;
      end else begin
        serial_phy_power_control[sler_pkg::PWR_CMD_MSB:sler_pkg::PWR_CMD_LSB]
          <= sler_pkg::PWR_CMD_ON;
      end
      link_up   <= (st_nxt == sler_pkg::ST_LINK);
      oob_start <= (st_nxt == sler_pkg::ST_OOB) && (st_r != sler_pkg::ST_OOB || port_reset);
    end
  end

  // ----------------------------------------------------------------
  // Receive path; locked link stops accepting, so data stalls upstream
  // ----------------------------------------------------------------
  assign fifo_in_valid = rx_valid && !locked && !ovf;

  // Own copy of the FIFO fill, so ready drops on the same edge that takes the last slot
  localparam int unsigned OW = $clog2(sler_pkg::FIFO_DEPTH) + 1;
  logic [OW-1:0] occ_r;
  logic [OW-1:0] occ_nxt;
  logic          fifo_push;
  logic          fifo_pop;
  assign fifo_push = fifo_in_valid && rx_ready && fifo_in_ready;
  assign fifo_pop  = out_valid && out_ready;
  assign occ_nxt   = occ_r + OW'(fifo_push) - OW'(fifo_pop);
  always_ff @(posedge clk) begin
    if (srst || port_reset) begin
      occ_r <= '0;
    end else begin
      occ_r <= occ_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_ready <= 1'b0;
    end else begin
      rx_ready <= (st_nxt == sler_pkg::ST_LINK) && !port_reset &&
                  (occ_nxt < OW'(sler_pkg::FIFO_DEPTH));
    end
  end

  sler_fifo #(
    .WIDTH (FW),
    .DEPTH (sler_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .flush     (port_reset),
    .in_data   (rx_dw),
    .in_valid  (fifo_in_valid && rx_ready),
    .in_ready  (fifo_in_ready),
    .out_data  (out_dw),
    .out_valid (out_valid),
    .out_ready (out_ready)
  );
endmodule

//--- tb/sler_checker.sv
// Checker: port properties of the link recovery block
`timescale 1ns/10ps
module sler_checker #(
  parameter int unsigned TMO_CYC = 50
) (
  input wire logic                clk,
  input wire logic                srst,
  input wire logic                port_reset,
  input wire logic                link_illegal,
  input wire logic                cmd_active,
  input wire logic                cmd_done,
  input wire logic                rx_ready,
  input wire logic [31:0]         port_irq_status,
  input wire logic [31:0]         port_error,
  input wire sler_pkg::sler_err_t err_flags,
  input wire logic [31:0]         serial_phy_power_control,
  input wire logic                link_up,
  input wire logic                oob_start
);
  localparam int OFF = sler_pkg::PWR_OFF_CYC;
  logic [7:0]  pwr;
  logic [7:0]  off_r;
  logic [15:0] act_r;
  logic        srst_q;
  assign pwr = serial_phy_power_control[21:14];
  // Delayed reset keeps the reset-time zero out of the off count
  always_ff @(posedge clk) srst_q <= srst;
  always_ff @(posedge clk) begin
    if (srst || srst_q || pwr != 8'h00) off_r <= 8'h00;
    else if (off_r != 8'hff) off_r <= off_r + 8'h01;
  end
  always_ff @(posedge clk) begin
    if (srst || !cmd_active || cmd_done || err_flags.cmd_tmo) act_r <= 16'h0000;
    else act_r <= act_r + 16'h0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_req;
    $rose(port_reset);
  endsequence
  sequence s_pulse;
    oob_start ##1 !oob_start;
  endsequence
  a_fatal_bits_set: assert property (link_illegal && link_up
    |=> port_irq_status[27] && port_error[23]) else $error("fatal bits not set");
  a_lock_stalls_rx: assert property (err_flags.ifs || err_flags.fifo_ovf
    |=> !rx_ready) else $error("receive not stalled in lock");
  a_lock_holds: assert property (err_flags.ifs && !port_reset
    |=> err_flags.ifs) else $error("lock left without port reset");
  a_reset_clears: assert property (port_reset && !link_illegal
    |=> !port_irq_status[27] && !port_error[23]) else $error("flags kept");
  a_oob_restart: assert property (s_req |=> s_pulse)
    else $error("no out-of-band restart");
  a_pwr_field: assert property ((pwr == 8'h00 || pwr == 8'h02) &&
    serial_phy_power_control[31:22] == 10'h000 && serial_phy_power_control[13:0] == 14'h0000)
    else $error("bad power control value");
  a_off_length: assert property (pwr == 8'h02 && off_r != 8'h00
    |-> off_r == OFF) else $error("power-down length wrong");
  a_tmo_count: assert property ($rose(err_flags.cmd_tmo)
    |-> act_r + 2 >= TMO_CYC && act_r <= TMO_CYC + 1) else $error("timeout count wrong");
endmodule
bind sler_core sler_checker #(.TMO_CYC(TMO_CYC)) u_chk (.*);

//--- tb/sler_drive_model.sv
// Drive-side model: frame source and receiver lock
`timescale 1ns/10ps
module sler_drive_model (
  input  wire logic             clk,
  input  wire logic             go,
  input  wire logic [3:0]       nw,
  input  wire logic             reg_fis,
  input  wire logic             rx_ready,
  input  wire logic             link_up,
  input  wire logic             relock,
  input  wire logic [7:0]       pwr,
  output sler_pkg::sler_rx_dw_t rx_dw,
  output logic                  rx_valid,
  output logic                  phy_lock_pin,
  output logic                  drive_present_pin
);
  logic [3:0] i_r = 4'h0;
  logic       pd_r = 1'b0;
  initial rx_valid = 1'b0;
  initial phy_lock_pin = 1'b1;
  assign drive_present_pin = phy_lock_pin;
  // Idle data is inverted so a stale word never looks valid
  assign rx_dw = '{rx_valid && i_r == 4'h0, i_r == nw - 4'h1, reg_fis,
                   rx_valid ? {28'h0a5c3e1, i_r} : {28'hf5a3c1e, ~i_r}};
  always @(posedge clk) begin
    // Receiver regains lock only after a full power-down and power-up
    if (relock) begin
      phy_lock_pin <= 1'b0;
      pd_r <= 1'b0;
    end else if (pwr == 8'h00) begin
      pd_r <= 1'b1;
    end else if (pd_r) begin
      phy_lock_pin <= 1'b1;
      pd_r <= 1'b0;
    end
    if (!link_up) rx_valid <= 1'b0;
    else if (rx_valid && rx_ready) begin
      i_r <= i_r + 4'h1;
      rx_valid <= i_r + 4'h1 != nw;
    end else if (go) begin
      i_r <= 4'h0;
      rx_valid <= 1'b1;
    end
  end
endmodule

//--- tb/sler_core_test.sv
// Testbench: recovery scenarios for the link error block
`timescale 1ns/10ps
module sler_core_test;
  localparam int TMO = 50;
  logic clk = 1'b0, srst = 1'b1, port_reset = 1'b0, link_illegal = 1'b0, go = 1'b0;
  logic cont_corrupt = 1'b0, cmd_active = 1'b0, low_power = 1'b0, pll_relock = 1'b0;
  logic reg_fis = 1'b0, out_ready = 1'b0, cmd_done = 1'b0;
  logic [3:0] nw = 4'h0;
  logic rx_valid, rx_ready, out_valid, link_up, oob_start, lock, pres;
  logic [31:0] irq, perr, pwr_ctl;
  sler_pkg::sler_rx_dw_t rx_dw, out_dw;
  sler_pkg::sler_err_t err_flags;
  int n_errors = 0, checks_done = 0, cyc = 0;
  sler_core #(.TMO_CYC(TMO)) uut (
    .clk(clk), .srst(srst), .port_reset(port_reset), .link_illegal(link_illegal),
    .cont_corrupt(cont_corrupt), .cmd_active(cmd_active), .cmd_done(cmd_done),
    .low_power(low_power), .pll_relock(pll_relock), .phy_lock_pin(lock),
    .drive_present_pin(pres), .rx_dw(rx_dw), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .out_dw(out_dw), .out_valid(out_valid), .out_ready(out_ready),
    .port_irq_status(irq), .port_error(perr), .err_flags(err_flags),
    .serial_phy_power_control(pwr_ctl), .link_up(link_up), .oob_start(oob_start));
  sler_drive_model u_drv (
    .clk(clk), .go(go), .nw(nw), .reg_fis(reg_fis), .rx_ready(rx_ready),
    .link_up(link_up), .relock(pll_relock && low_power), .pwr(pwr_ctl[21:14]),
    .rx_dw(rx_dw), .rx_valid(rx_valid), .phy_lock_pin(lock), .drive_present_pin(pres));
  always #5 clk = ~clk;
  task automatic chk(input logic c, input string m);
    checks_done++;
    if (c !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_link();
    int k;
    k = 0;
    while (link_up !== 1'b1 && k < 1000) begin
      @(posedge clk);
      k++;
    end
    chk(link_up === 1'b1 && k >= sler_pkg::OOB_CYC, "link timing");
  endtask
  task automatic pulse_reset();
    @(posedge clk);
    port_reset <= 1'b1;
    @(posedge clk);
    port_reset <= 1'b0;
    #1 chk(oob_start === 1'b1 && irq[27] === 1'b0 && perr[23] === 1'b0, "reset");
    chk(err_flags.fifo_ovf === 1'b0 && err_flags.ifs === 1'b0, "flags kept");
    wait_link();
  endtask
  task automatic frame(input logic [3:0] n, input logic rf, input logic stall);
    int got, k;
    got = 0;
    k = 0;
    @(posedge clk);
    nw <= n;
    reg_fis <= rf;
    go <= 1'b1;
    out_ready <= !stall;
    @(posedge clk);
    go <= 1'b0;
    while (got < n && k < 300) begin
      @(posedge clk);
      k++;
      if (stall && k == 40) begin
        chk(rx_ready === 1'b0, "never full");
        out_ready <= 1'b1;
      end
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
        chk(out_dw.data === {28'h0a5c3e1, got[3:0]} && out_dw.sof === (got == 0), "word");
        chk(out_dw.eof === (got == n - 1) && out_dw.reg_fis === rf, "frame marks");
        got++;
      end
    end
    repeat (3) @(posedge clk);
    #1 chk(got == n && out_valid === 1'b0, "count");
  endtask
  task automatic t_oversize();
    @(posedge clk);
    nw <= 4'h9;
    reg_fis <= 1'b1;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (30) @(posedge clk);
    chk(err_flags.fifo_ovf === 1'b1 && rx_ready === 1'b0, "no lock");
    pulse_reset();
  endtask
  task automatic t_illegal();
    @(posedge clk);
    link_illegal <= 1'b1;
    @(posedge clk);
    link_illegal <= 1'b0;
    @(posedge clk);
    #1 chk(irq[27] === 1'b1 && perr[23] === 1'b1 && rx_ready === 1'b0, "fatal");
    chk(err_flags.ifs === 1'b1 && err_flags.lseq === 1'b1, "fatal flags");
    pulse_reset();
  endtask
  task automatic t_cont();
    @(posedge clk);
    cmd_active <= 1'b1;
    repeat (TMO - 10) @(posedge clk);
    cmd_done <= 1'b1;
    @(posedge clk);
    cmd_done <= 1'b0;
    repeat (TMO - 10) @(posedge clk);
    chk(err_flags.cmd_tmo === 1'b0, "completion ignored");
    cmd_done <= 1'b1;
    cont_corrupt <= 1'b1;
    @(posedge clk);
    cmd_done <= 1'b0;
    cont_corrupt <= 1'b0;
    repeat (TMO - 5) @(posedge clk);
    chk(err_flags.cmd_tmo === 1'b0, "early timeout");
    repeat (10) @(posedge clk);
    chk(err_flags.cmd_tmo === 1'b1 && rx_ready === 1'b0, "no timeout");
    cmd_active <= 1'b0;
    pulse_reset();
  endtask
  task automatic t_relock();
    int k;
    k = 0;
    @(posedge clk);
    low_power <= 1'b1;
    pll_relock <= 1'b1;
    @(posedge clk);
    pll_relock <= 1'b0;
    while (pwr_ctl[21:14] !== 8'h00 && k < 50) begin
      @(posedge clk);
      k++;
    end
    low_power <= 1'b0;
    #1 chk(err_flags.rx_lost === 1'b1, "no receive loss");
    k = 0;
    while (pwr_ctl[21:14] === 8'h00 && k < 400) begin
      @(posedge clk);
      k++;
    end
    chk(k == sler_pkg::PWR_OFF_CYC && pwr_ctl[21:14] === 8'h02, "power cycle");
    wait_link();
    chk(err_flags.rx_lost === 1'b0, "receive loss kept");
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      results();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1 chk(pwr_ctl === 32'h00008000 && link_up === 1'b0, "after reset");
    wait_link();
    frame(4'h8, 1'b1, 1'b0);
    frame(4'he, 1'b0, 1'b1);
    t_oversize();
    frame(4'h3, 1'b1, 1'b0);
    t_illegal();
    t_cont();
    t_relock();
    results();
  end
endmodule
